// File: rli_pkg.sv
`default_nettype none
package rli_pkg;
	// Register indices on the register bus (3-bit index)
	localparam logic [2:0] IDX_LOOPBACK_AND_IDENT       = 3'h0;
	localparam logic [2:0] IDX_DATA_SET_CONTROL         = 3'h2;
	localparam logic [2:0] IDX_CLOCK_CODING_MAINTENANCE = 3'h4;
	localparam logic [2:0] IDX_DATA_SET_STATUS          = 3'h5;
	// Control register fields
	localparam int CTL_DTR       = 0;
	localparam int CTL_RTS       = 1;
	localparam int CTL_NEW_SYNC  = 2;
	localparam int CTL_RATE      = 3;
	localparam int CTL_SEC_RTS   = 4;
	localparam int CTL_TL2       = 7;
	// Maintenance register fields
	localparam int MNT_DIRECT    = 1;
	localparam int MNT_BUSY_OUT  = 2;
	localparam int MNT_NRZI      = 3;
	localparam int MNT_LOCAL     = 4;
	localparam int MNT_REMOTE    = 5;
	localparam int MNT_TL4       = 6;
	// Status register fields
	localparam int STS_DSR       = 0;
	localparam int STS_CTS       = 1;
	localparam int STS_CARRIER   = 2;
	localparam int STS_RING      = 3;
	localparam int STS_SEC_CD    = 4;
	localparam int STS_TEST_MODE = 5;
	localparam int STS_RX_DATA   = 6;
	// Reset values
	localparam logic [7:0] CONTROL_RESET = 8'h00;
	localparam logic [7:0] MAINT_RESET   = 8'h00;
	// Identification codes: arbitrary values
	localparam logic [5:0] IDENT_NRZI    = 6'h2A;
	localparam logic [5:0] IDENT_BASIC   = 6'h15;
	// Link-side line outputs
	typedef struct packed {
		logic dtr;
		logic rts;
		logic new_sync_line;
		logic rate_selector;
		logic secondary_rts;
		logic busy_out;
		logic local_loop_request;
		logic remote_loop_request;
	} rli_ctl_s;
	// Modem status inputs
	typedef struct packed {
		logic dsr;
		logic cts;
		logic carrier;
		logic ring;
		logic secondary_carrier_detect;
		logic test_mode_indication;
	} rli_sts_s;
endpackage
`default_nettype wire

// File: rli_buf2.sv
`default_nettype none
// Two-entry skid buffer; ready depends only on fill level
module rli_buf2 #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input  wire logic             i_clk,
	input  wire logic             i_reset_n,
	// Fill side
	input  wire logic             i_valid,
	input  wire logic [WIDTH-1:0] i_data,
	output logic                  o_ready,
	// Drain side
	output logic                  o_valid,
	output logic [WIDTH-1:0]      o_data,
	input  wire logic             i_ready
);
	logic [WIDTH-1:0] mem_r [2];
	logic             rd_r;
	logic             wr_r;
	logic [1:0]       cnt_r;
	wire              push = i_valid && (cnt_r != 2'd2);
	wire              pop  = (cnt_r != 2'd0) && i_ready;

	assign o_ready = (cnt_r != 2'd2);
	assign o_valid = (cnt_r != 2'd0);
	assign o_data  = mem_r[rd_r];

	// Pointers and count
	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			rd_r  <= 1'b0;
			wr_r  <= 1'b0;
			cnt_r <= 2'd0;
		end else begin
			if (push) begin
				wr_r <= ~wr_r;
			end
			if (pop) begin
				rd_r <= ~rd_r;
			end
			cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
		end
	end

	// Storage
	always_ff @(posedge i_clk) begin
		if (push) begin
			mem_r[wr_r] <= i_data;
		end
	end
endmodule
`default_nettype wire

// File: rli_line_interface.sv
`default_nettype none
module rli_line_interface #(
	parameter bit NRZI_SUPPORT = 1'b1
) (
	// Adapter side clock and reset
	input  wire logic                i_clk,
	input  wire logic                i_reset_n,
	// Register bus
	input  wire logic                i_reg_strobe,
	input  wire logic [2:0]          i_reg_index,
	input  wire logic [7:0]          i_reg_wdata,
	output logic [7:0]               o_reg_rdata,
	// Adapter serial data, adapter clock domain
	input  wire logic                i_tx_valid,
	input  wire logic                i_tx_bit,
	output logic                     o_tx_ready,
	output logic                     o_rx_valid,
	output logic                     o_rx_bit,
	input  wire logic                i_rx_ready,
	// Adapter clocks
	input  wire logic                i_direct_clock,
	output logic                     o_adapter_tx_clock,
	output logic                     o_adapter_rx_clock,
	output logic                     o_bus_direct_clock,
	// Link clock and modem lines
	input  wire logic                i_link_clk,
	input  wire logic                i_dce_transmit_timing,
	input  wire logic                i_dce_receive_timing,
	input  wire logic                i_line_rx_data,
	input  wire rli_pkg::rli_sts_s   i_modem_status,
	output logic                     o_line_tx_data,
	output rli_pkg::rli_ctl_s        o_modem_control
);
	////////////////////////////////////////////////////////////////////////
	// Registers on the adapter clock
	logic [7:0]           control_r;
	logic [7:0]           maint_r;
	logic [7:0]           rdata_r;
	rli_pkg::rli_ctl_s    ctl_r;
	logic                 aclk_tx_r;
	logic                 aclk_rx_r;
	logic                 bus_clk_r;

	// Write decode: writes only land on the write-only indices
	wire wr_control = i_reg_strobe &&
		(i_reg_index == rli_pkg::IDX_DATA_SET_CONTROL);
	wire wr_maint   = i_reg_strobe &&
		(i_reg_index == rli_pkg::IDX_CLOCK_CODING_MAINTENANCE);

	// Stored fields; unused control bits are never stored
	wire [7:0] control_mask = 8'h9F;
	wire [7:0] maint_mask   = NRZI_SUPPORT ? 8'h7E : 8'h76;

	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			control_r <= rli_pkg::CONTROL_RESET;
			maint_r   <= rli_pkg::MAINT_RESET;
		end else begin
			if (wr_control) begin
				control_r <= i_reg_wdata & control_mask;
			end
			if (wr_maint) begin
				maint_r <= i_reg_wdata & maint_mask;
			end
		end
	end

	wire tl2        = control_r[rli_pkg::CTL_TL2];
	wire tl4        = maint_r[rli_pkg::MNT_TL4];
	wire direct_sel = maint_r[rli_pkg::MNT_DIRECT];
	wire nrzi_on    = maint_r[rli_pkg::MNT_NRZI];

	////////////////////////////////////////////////////////////////////////
	// Status lines from the modem, two-stage synchronised
	rli_pkg::rli_sts_s sts_m_r;
	rli_pkg::rli_sts_s sts_s_r;
	logic              rxd_m_r;
	logic              rxd_s_r;

	always_ff @(posedge i_clk) begin
		sts_m_r <= i_modem_status;
		sts_s_r <= sts_m_r;
		rxd_m_r <= i_line_rx_data;
		rxd_s_r <= rxd_m_r;
	end

	// Status byte; bit 7 reads zero
	wire [7:0] status_byte;
	assign status_byte[rli_pkg::STS_DSR]       = sts_s_r.dsr;
	assign status_byte[rli_pkg::STS_CTS]       = sts_s_r.cts;
	assign status_byte[rli_pkg::STS_CARRIER]   = sts_s_r.carrier;
	assign status_byte[rli_pkg::STS_RING]      =
		sts_s_r.ring | direct_sel;
	assign status_byte[rli_pkg::STS_SEC_CD]    =
		sts_s_r.secondary_carrier_detect;
	assign status_byte[rli_pkg::STS_TEST_MODE] =
		sts_s_r.test_mode_indication;
	assign status_byte[rli_pkg::STS_RX_DATA]   = rxd_s_r;
	assign status_byte[7]                      = 1'b0;

	// Ident byte; code never writable, loop bits raw
	wire [5:0] ident_code = NRZI_SUPPORT ?
		rli_pkg::IDENT_NRZI : rli_pkg::IDENT_BASIC;
	wire [7:0] ident_byte = {ident_code, tl4, tl2};

	// Read decode; write-only and unmapped indices read zero
	wire [7:0] rd_sel =
		(i_reg_index == rli_pkg::IDX_LOOPBACK_AND_IDENT) ? ident_byte :
		(i_reg_index == rli_pkg::IDX_DATA_SET_STATUS)    ? status_byte :
		8'h00;

	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			rdata_r <= 8'h00;
		end else begin
			rdata_r <= rd_sel;
		end
	end
	assign o_reg_rdata = rdata_r;

	////////////////////////////////////////////////////////////////////////
	// Clock routing. Clocks are sampled into flops, so the routed clocks
	// carry three adapter-clocks of delay and suit only slow line rates.
	logic dct_m_r;
	logic dct_s_r;
	logic dcr_m_r;
	logic dcr_s_r;
	logic dir_m_r;
	logic dir_s_r;

	always_ff @(posedge i_clk) begin
		dct_m_r <= i_dce_transmit_timing;
		dct_s_r <= dct_m_r;
		dcr_m_r <= i_dce_receive_timing;
		dcr_s_r <= dcr_m_r;
		dir_m_r <= i_direct_clock;
		dir_s_r <= dir_m_r;
	end

	wire tx_clk_sel  = direct_sel ? dir_s_r : dct_s_r;
	wire bus_clk_sel = direct_sel & dir_s_r;

	// Modem control lines; direct clock replaces sync and rate lines
	rli_pkg::rli_ctl_s ctl_nxt;
	always_comb begin
		ctl_nxt.dtr                 = control_r[rli_pkg::CTL_DTR];
		ctl_nxt.rts                 = control_r[rli_pkg::CTL_RTS];
		ctl_nxt.new_sync_line       = direct_sel ? dir_s_r :
			control_r[rli_pkg::CTL_NEW_SYNC];
		ctl_nxt.rate_selector       = direct_sel ? dir_s_r :
			control_r[rli_pkg::CTL_RATE];
		ctl_nxt.secondary_rts       = control_r[rli_pkg::CTL_SEC_RTS];
		ctl_nxt.busy_out            = maint_r[rli_pkg::MNT_BUSY_OUT];
		ctl_nxt.local_loop_request  = maint_r[rli_pkg::MNT_LOCAL];
		ctl_nxt.remote_loop_request = maint_r[rli_pkg::MNT_REMOTE];
	end

	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			ctl_r     <= '0;
			aclk_tx_r <= 1'b0;
			aclk_rx_r <= 1'b0;
			bus_clk_r <= 1'b0;
		end else begin
			ctl_r     <= ctl_nxt;
			aclk_tx_r <= tx_clk_sel;
			aclk_rx_r <= dcr_s_r;
			bus_clk_r <= bus_clk_sel;
		end
	end
	assign o_modem_control    = ctl_r;
	assign o_adapter_tx_clock = aclk_tx_r;
	assign o_adapter_rx_clock = aclk_rx_r;
	assign o_bus_direct_clock = bus_clk_r;

	////////////////////////////////////////////////////////////////////////
	// Transmit path: buffer, NRZI encode, hand to link by toggle handshake
	logic buf_valid;
	logic buf_bit;
	logic buf_take;
	logic nrzi_tx_r;
	logic tx_bit_r;
	logic tx_req_r;
	// Link-domain acknowledge toggle, read here through two flops
	logic tx_ack_r;
	logic ack_m_r;
	logic ack_s_r;
	logic rx_bit_r;
	logic rx_valid_r;

	rli_buf2 #(
		.WIDTH (1)
	) u_tx_buf (
		.i_clk     (i_clk),
		.i_reset_n (i_reset_n),
		.i_valid   (i_tx_valid),
		.i_data    (i_tx_bit),
		.o_ready   (o_tx_ready),
		.o_valid   (buf_valid),
		.o_data    (buf_bit),
		.i_ready   (buf_take)
	);

	// Link idle once ack toggle matches request toggle
	wire link_idle = (ack_s_r == tx_req_r);
	// Loop-back word goes to receive side, which must have room
	wire rx_room   = !rx_valid_r || i_rx_ready;
	assign buf_take = buf_valid && (tl2 ? rx_room : link_idle);

	// NRZI: a zero toggles the line level, a one holds it
	wire nrzi_enc  = buf_bit ? nrzi_tx_r : ~nrzi_tx_r;
	wire coded_tx  = (NRZI_SUPPORT && nrzi_on) ? nrzi_enc :
		buf_bit;

	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			nrzi_tx_r <= 1'b1;
			tx_bit_r  <= 1'b1;
			tx_req_r  <= 1'b0;
			ack_m_r   <= 1'b0;
			ack_s_r   <= 1'b0;
		end else begin
			ack_m_r <= tx_ack_r;
			ack_s_r <= ack_m_r;
			if (buf_take && !tl2) begin
				tx_bit_r  <= coded_tx;
				nrzi_tx_r <= coded_tx;
				tx_req_r  <= ~tx_req_r;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Link domain: line driver and receive sampler
	logic req_m_r;
	logic req_s_r;
	logic line_tx_r;
	logic tl2_m_r;
	logic tl2_s_r;
	logic lrx_m_r;
	logic lrx_s_r;
	logic lrx_tog_r;
	logic lrx_bit_r;

	always_ff @(posedge i_link_clk) begin
		if (!i_reset_n) begin
			req_m_r   <= 1'b0;
			req_s_r   <= 1'b0;
			tx_ack_r  <= 1'b0;
			line_tx_r <= 1'b1;
			tl2_m_r   <= 1'b0;
			tl2_s_r   <= 1'b0;
			lrx_m_r   <= 1'b1;
			lrx_s_r   <= 1'b1;
			lrx_tog_r <= 1'b0;
			lrx_bit_r <= 1'b1;
		end else begin
			req_m_r <= tx_req_r;
			req_s_r <= req_m_r;
			tl2_m_r <= tl2;
			tl2_s_r <= tl2_m_r;
			lrx_m_r <= i_line_rx_data;
			lrx_s_r <= lrx_m_r;
			// Held marking while test loop two is on
			line_tx_r <= tl2_s_r ? 1'b1 :
				((req_s_r != tx_ack_r) ? tx_bit_r : line_tx_r);
			if (req_s_r != tx_ack_r) begin
				tx_ack_r <= req_s_r;
				// One received bit per transmitted bit slot
				lrx_tog_r <= ~lrx_tog_r;
				lrx_bit_r <= lrx_s_r;
			end
		end
	end
	assign o_line_tx_data = line_tx_r;

	////////////////////////////////////////////////////////////////////////
	// Receive path back in adapter domain, NRZI decode
	logic rtog_m_r;
	logic rtog_s_r;
	logic rtog_d_r;
	logic nrzi_rx_r;

	wire rx_event  = (rtog_s_r != rtog_d_r);
	// Loop-back feeds raw transmit data into the receive path
	wire raw_rx    = tl2 ? buf_bit : lrx_bit_r;
	wire dec_rx    = (raw_rx == nrzi_rx_r);
	wire coded_rx  = (NRZI_SUPPORT && nrzi_on && !tl2) ? dec_rx :
		raw_rx;
	wire rx_load   = tl2 ? buf_take : rx_event;

	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			rtog_m_r   <= 1'b0;
			rtog_s_r   <= 1'b0;
			rtog_d_r   <= 1'b0;
			nrzi_rx_r  <= 1'b1;
			rx_bit_r   <= 1'b1;
			rx_valid_r <= 1'b0;
		end else begin
			rtog_m_r <= lrx_tog_r;
			rtog_s_r <= rtog_m_r;
			rtog_d_r <= rtog_s_r;
			if (rx_load) begin
				rx_bit_r   <= coded_rx;
				rx_valid_r <= 1'b1;
				nrzi_rx_r  <= raw_rx;
			end else if (i_rx_ready) begin
				rx_valid_r <= 1'b0;
			end
		end
	end
	assign o_rx_valid = rx_valid_r;
	assign o_rx_bit   = rx_bit_r;
endmodule
`default_nettype wire

// File: rli_line_interface_props.sv
`default_nettype none
module rli_line_interface_props #(
	parameter bit NRZI_SUPPORT = 1'b1
) (
	// Watched ports
	input wire logic              i_clk,
	input wire logic              i_reset_n,
	input wire logic              i_reg_strobe,
	input wire logic [2:0]        i_reg_index,
	input wire logic [7:0]        i_reg_wdata,
	input wire logic [7:0]        o_reg_rdata,
	input wire logic              o_line_tx_data,
	input wire rli_pkg::rli_ctl_s o_modem_control
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [5:0] ID = NRZI_SUPPORT ? rli_pkg::IDENT_NRZI
		: rli_pkg::IDENT_BASIC;
	// Access decode
	wire wr_c  = i_reg_strobe && i_reg_index == rli_pkg::IDX_DATA_SET_CONTROL;
	wire wr_m  = i_reg_strobe
		&& i_reg_index == rli_pkg::IDX_CLOCK_CODING_MAINTENANCE;
	wire rd_id = i_reg_index == rli_pkg::IDX_LOOPBACK_AND_IDENT;
	wire rd_st = i_reg_index == rli_pkg::IDX_DATA_SET_STATUS;
	////////////////////////////////////////////////////////////////////////
	// Cycles since a mode bit was set; saturates so it never wraps
	logic [3:0] tl2_n, dir_n;
	always_ff @(posedge i_clk) begin
		if (!i_reset_n || wr_c && !i_reg_wdata[7])
			tl2_n <= '0;
		else if (tl2_n != 15 && (wr_c || tl2_n != 0))
			tl2_n <= tl2_n + 4'd1;
		if (!i_reset_n || wr_m && !i_reg_wdata[1])
			dir_n <= '0;
		else if (dir_n != 15 && (wr_m || dir_n != 0))
			dir_n <= dir_n + 4'd1;
	end
	////////////////////////////////////////////////////////////////////////
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_reset_n);
	sequence s_wc;
		wr_c;
	endsequence
	sequence s_wm;
		wr_m;
	endsequence
	a_ctl_lines: assert property (s_wc |=> ##1
		o_modem_control.dtr == $past(i_reg_wdata[0], 2)
		&& o_modem_control.rts == $past(i_reg_wdata[1], 2)
		&& o_modem_control.secondary_rts == $past(i_reg_wdata[4], 2))
		else $error("control line mismatch");
	a_busy_out: assert property (s_wm |=> ##1
		o_modem_control.busy_out == $past(i_reg_wdata[2], 2))
		else $error("busy out mismatch");
	a_loop_req: assert property (s_wm |=> ##1
		o_modem_control.local_loop_request == $past(i_reg_wdata[4], 2)
		&& o_modem_control.remote_loop_request == $past(i_reg_wdata[5], 2))
		else $error("loop request mismatch");
	a_loop_echo: assert property (s_wc ##1 rd_id |=>
		o_reg_rdata[0] == $past(i_reg_wdata[7], 2))
		else $error("loop echo mismatch");
	a_ident_code: assert property (rd_id |=> o_reg_rdata[7:2] == ID)
		else $error("ident code mismatch");
	a_status_msb: assert property (rd_st |=> !o_reg_rdata[7])
		else $error("status bit 7 set");
	a_wo_reads: assert property (!rd_id && !rd_st |=> o_reg_rdata == '0)
		else $error("write-only read not zero");
	a_mark_hold: assert property (tl2_n > 8 |-> o_line_tx_data)
		else $error("line not marking");
	a_ring_direct: assert property (dir_n > 8 && rd_st |=> o_reg_rdata[3])
		else $error("ring not one");
endmodule
bind rli_line_interface rli_line_interface_props #(
	.NRZI_SUPPORT(NRZI_SUPPORT)
) u_props (.i_clk, .i_reset_n, .i_reg_strobe, .i_reg_index, .i_reg_wdata,
	.o_reg_rdata, .o_line_tx_data, .o_modem_control);
`default_nettype wire

// File: rli_modem_model.sv
`default_nettype none
// Behavioural modem: free-running element timing, loops on request
module rli_modem_model #(
	parameter int TM_DELAY = 4
) (
	// Link clock
	input  wire logic              i_link_clk,
	// Lines from the device, and status line levels to present
	input  wire rli_pkg::rli_ctl_s i_ctl,
	input  wire logic              i_line_tx,
	input  wire logic [4:0]        i_lines,
	// Lines toward the device
	output rli_pkg::rli_sts_s      o_sts,
	output logic                   o_tx_timing,
	output logic                   o_rx_timing,
	output logic                   o_line_rx
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2:0] div_r = '0;
	logic [7:0] tm_r  = '0;
	wire        loop  = i_ctl.local_loop_request | i_ctl.remote_loop_request;
	// Test mode answers late, as a slow modem would
	always_ff @(posedge i_link_clk) begin
		div_r <= div_r + 3'd1;
		tm_r  <= {tm_r[6:0], loop};
	end
	// Not looping: line data changes every cycle, never a stale level
	assign o_line_rx   = loop ? i_line_tx : div_r[0];
	assign o_tx_timing = div_r[2];
	assign o_rx_timing = ~div_r[1];
	assign o_sts = '{i_lines[0], i_lines[1], i_lines[2], i_lines[3],
		i_lines[4], tm_r[TM_DELAY]};
endmodule
`default_nettype wire

// File: rli_line_interface_tb.sv
`default_nettype none
module rli_line_interface_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [7:0] IDB = {rli_pkg::IDENT_NRZI, 2'b00};
	logic       i_clk = 0, i_link_clk = 0, i_reset_n = 0;
	logic       stb = 0, tx_v = 0, tx_b = 0, rx_r = 1, dclk = 0;
	logic [2:0] idx = 0;
	logic [7:0] wd = 0, rd, got;
	logic [4:0] lines = 0;
	logic       tx_r, rx_v, rx_b, atx, arx, bdc, db, dd, lrx, ltx;
	rli_pkg::rli_sts_s sts;
	rli_pkg::rli_ctl_s ctl;
	int num_errors = 0, samples_checked = 0;
	int n_bdc, n_ns, n_arx, n_ltx, n_ref;
	logic q[$];
	logic [7:0] ctab[4] = '{8'h1F, 8'h15, 8'h0A, 8'h60};
	logic [7:0] mtab[3] = '{8'h04, 8'h10, 8'h20};
	// Clocks, phases unrelated
	initial forever #10 i_clk = ~i_clk;
	initial begin
		#1.7;
		forever #3 i_link_clk = ~i_link_clk;
	end
	rli_line_interface dut (.i_clk, .i_reset_n, .i_reg_strobe(stb),
		.i_reg_index(idx), .i_reg_wdata(wd), .o_reg_rdata(rd),
		.i_tx_valid(tx_v), .i_tx_bit(tx_b), .o_tx_ready(tx_r),
		.o_rx_valid(rx_v), .o_rx_bit(rx_b), .i_rx_ready(rx_r),
		.i_direct_clock(dclk), .o_adapter_tx_clock(atx),
		.o_adapter_rx_clock(arx), .o_bus_direct_clock(bdc), .i_link_clk,
		.i_dce_transmit_timing(db), .i_dce_receive_timing(dd),
		.i_line_rx_data(lrx), .i_modem_status(sts),
		.o_line_tx_data(ltx), .o_modem_control(ctl));
	rli_modem_model modem (.i_link_clk, .i_ctl(ctl), .i_line_tx(ltx),
		.i_lines(lines), .o_sts(sts), .o_tx_timing(db), .o_rx_timing(dd),
		.o_line_rx(lrx));
	////////////////////////////////////////////////////////////////////////
	// Edge counters and receive collector
	always @(bdc) n_bdc++;
	always @(ctl.new_sync_line) n_ns++;
	always @(arx) n_arx++;
	always @(ltx) n_ltx++;
	always @(posedge i_clk) begin
		dclk <= ~dclk;
		if (tx_v && !tx_r) n_ref++;
		if (rx_v && rx_r) q.push_back(rx_b);
	end
	task automatic chk(input logic [7:0] seen, exp);
		samples_checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD t=%0t seen %h want %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [2:0] i, input logic [7:0] d);
		@(posedge i_clk);
		stb <= 1;
		idx <= i;
		wd  <= d;
		@(posedge i_clk);
		stb <= 0;
		repeat (3) @(posedge i_clk);
	endtask
	task automatic rc(input logic [2:0] i, input logic [7:0] m, e);
		@(posedge i_clk);
		idx <= i;
		repeat (2) @(posedge i_clk);
		#1 chk(rd & m, e);
	endtask
	// Hold valid and bit until ready is seen at an edge
	task automatic send(input logic b);
		@(posedge i_clk);
		tx_v <= 1;
		tx_b <= b;
		#1;
		for (int g = 0; g < 200 && !tx_r; g++) @(posedge i_clk) #1;
		@(posedge i_clk);
		tx_v <= 0;
	endtask
	task automatic xfer(input logic [7:0] bits, input int n, input logic st,
		input logic [7:0] exp);
		q.delete();
		@(posedge i_clk);
		rx_r <= !st;
		// Stall is let go while a sender still waits on a full buffer
		fork
			begin
				repeat (20) @(posedge i_clk);
				rx_r <= 1;
			end
		join_none
		for (int k = 0; k < n; k++) send(bits[k]);
		repeat (80) @(posedge i_clk);
		got = '0;
		for (int k = 0; k < n; k++) got[k] = q[k];
		chk(8'(q.size()), 8'(n));
		chk(got, exp & 8'((1 << n) - 1));
	endtask
	task automatic tally_and_finish;
		$display("checked %0d, mismatches %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// Watchdog well past the expected run
	initial begin
		#500_000;
		num_errors++;
		tally_and_finish();
	end
	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (16) @(posedge i_clk);
		i_reset_n <= 1;
		rc(0, 8'hFF, IDB); // ident
		for (int i = 1; i < 8; i++)
			if (i != 5) rc(3'(i), 8'hFF, 8'h00); // reads zero
		chk({7'h0, ltx}, 8'h01); // idle mark
		$display("test reset done");
		foreach (ctab[i]) begin
			wr(2, ctab[i]);
			chk(8'(ctl), {ctab[i][0], ctab[i][1], ctab[i][2], ctab[i][3],
				ctab[i][4], 3'b000}); // lines
		end
		// Maint bit 0 always zero, loops never both
		foreach (mtab[i]) begin
			wr(4, mtab[i]);
			repeat (10) @(posedge i_clk);
			chk(8'(ctl), {5'b0, mtab[i][2], mtab[i][4], mtab[i][5]});
			rc(5, 8'h20, {2'b0, mtab[i][4] | mtab[i][5], 5'b0}); // tm
		end
		wr(4, 8'h00);
		for (int v = 5'h0A; v < 32; v += 11) begin
			lines <= 5'(v);
			repeat (6) @(posedge i_clk);
			rc(5, 8'hBF, {3'b0, 5'(v)}); // status
		end
		lines <= 0;
		$display("test control and status done");
		wr(2, 8'h80);
		wr(4, 8'h40);
		rc(0, 8'h03, 8'h03); // echo
		rc(0, 8'hFC, IDB); // masked id
		n_ltx = 0;
		n_ref = 0;
		xfer(8'b1011_0010, 8, 1, 8'b1011_0010); // wrap
		chk(8'(n_ltx), 8'h00); // held mark
		chk({7'h0, n_ref != 0}, 8'h01); // buffer refused
		wr(2, 8'h00);
		wr(4, 8'h18);
		repeat (10) @(posedge i_clk);
		n_ltx = 0;
		// Line is sampled as each bit leaves, so the loop answer lags a slot
		xfer(8'h00, 4, 0, 8'h01); // coded loop
		chk(8'(n_ltx), 8'h04); // zeros toggle
		wr(4, 8'h10);
		xfer(8'b0000_1101, 4, 0, 8'h0B); // plain
		$display("test serial done");
		wr(4, 8'h00);
		n_bdc = 0;
		n_arx = 0;
		repeat (40) @(posedge i_clk);
		chk(8'(n_bdc), 8'h00); // unplugged
		chk({7'h0, n_arx != 0}, 8'h01); // modem clock
		wr(4, 8'h02);
		n_bdc = 0;
		n_ns = 0;
		repeat (40) @(posedge i_clk);
		chk({6'h0, n_bdc != 0, n_ns != 0}, 8'h03); // routed
		// Transmit clock and bus lead carry the same direct clock
		repeat (8) begin
			@(posedge i_clk);
			#1 chk({7'h0, atx}, {7'h0, bdc});
		end
		rc(5, 8'h08, 8'h08); // ring one
		$display("test clocking done");
		tally_and_finish();
	end
endmodule
`default_nettype wire
